// ---- src/stbs_consts.svh ----
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef STBS_CONSTS_SVH
`define STBS_CONSTS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define STBS_CLK_MHZ 125

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define STBS_ADDR_W 8
`define STBS_OFF_CTRL 8'h00
`define STBS_OFF_TOL 8'h04
`define STBS_OFF_SSDLY 8'h08
`define STBS_OFF_STATE 8'h0C
`define STBS_OFF_IRQ_STAT 8'h10
`define STBS_OFF_IRQ_CLR 8'h14
`define STBS_OFF_IRQ_EN 8'h18

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define STBS_CTRL_MODE_LSB 0
`define STBS_CTRL_BRAKE_CFG 2
`define STBS_CTRL_BRK_EN 3
`define STBS_MODE_ONBOARD 2'h0
`define STBS_MODE_TEL_BASIC 2'h1
`define STBS_MODE_TEL_EXT 2'h2
`define STBS_CTRL_RESET 4'h0

// ----------------------------------------
// State register fields
// ----------------------------------------
`define STBS_ST_EVENT 0
`define STBS_ST_FAULT 1
`define STBS_ST_TQ_OFF 2
`define STBS_ST_BRK_SAFE 3
`define STBS_ST_MOTOR_ON 4
`define STBS_ST_READY 5
`define STBS_ST_CAUSE_STAGE 6
`define STBS_ST_FVAL_LSB 16

// ----------------------------------------
// Fault value and timing
// ----------------------------------------
`define STBS_FAULT_DISCREPANCY 16'h0406
`define STBS_CNT_W 24
`define STBS_TOL_US 20
`define STBS_SSDLY_US 30
`define STBS_TOL_CYC (`STBS_TOL_US * `STBS_CLK_MHZ)
`define STBS_SSDLY_CYC (`STBS_SSDLY_US * `STBS_CLK_MHZ)

`endif

// ---- src/stbs_discrepancy.sv ----
// Two-channel discrepancy filter with tolerance timer
`timescale 1ns/1ns
`default_nettype none
`include "stbs_consts.svh"

module stbs_discrepancy (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic chan_a,
  input wire logic chan_b,
  input wire logic [`STBS_CNT_W-1:0] tolerance,
  output logic expired
);

  logic [`STBS_CNT_W-1:0] cnt_q;
  logic done_q;
  wire differ = chan_a ^ chan_b;
  wire at_limit = (cnt_q >= tolerance);

  // One pulse per continuous disagreement; agreement restarts the timer
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (!differ) begin
        cnt_q <= '0;
        done_q <= 1'b0;
      end else if (!at_limit) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (!done_q) begin
        done_q <= 1'b1;
        expired <= 1'b1;
      end
    end
  end

endmodule // stbs_discrepancy

`default_nettype wire

// ---- src/stbs_pkg.sv ----
// Types shared by the sequencer files
package stbs_pkg;

  // ----------------------------------------
  // Safety telegram control word 1
  // ----------------------------------------
  typedef struct packed {
    logic ack;
    logic [4:0] spare;
    logic safe_stop_deselect_ext;
    logic torque_off_deselect_ext;
  } stbs_cw1_s;

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  typedef struct packed {
    logic safe_stop_done;
    logic torque_off_on;
    logic discrepancy;
  } stbs_evt_s;

  // ----------------------------------------
  // Safe stop sequence
  // ----------------------------------------
  typedef enum logic [1:0] {
    STBS_SS_IDLE,
    STBS_SS_RAMP,
    STBS_SS_DONE
  } stbs_ss_e;

endpackage : stbs_pkg

// ---- src/stbs_top.sv ----
// Safe torque-off, brake control and safe stop sequencer
`timescale 1ns/1ns
`default_nettype none
`include "stbs_consts.svh"

// What this block does
// - Expiry on stage input reports fault 1030
// - Expiry also sets the internal event flag
// - Stage terminal toggle never acknowledges the event
// - Brake control active: configured, enabled, torque off
// - No switch-on while torque off is selected
// - Safe stop ramps with quick-stop time
// - Safe stop closes brake at standstill
// - Torque off at standstill or delay expiry
// - No switch-on while safe stop is selected
module stbs_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic stage_term_a,
  input wire logic stage_term_b,
  input wire logic failsafe_input,
  input wire logic safe_stop_deselect_basic,
  input wire stbs_pkg::stbs_cw1_s tel_cw1,
  input wire logic standard_ack_source,
  input wire logic run_command,
  input wire logic quick_stop_cmd_n,
  input wire logic at_standstill,
  input wire logic [`STBS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic internal_event_flag,
  output logic [15:0] fault_value_field,
  output logic torque_off_active_basic,
  output logic brake_control_safe,
  output logic close_brake_cmd,
  output logic release_brake_cmd,
  output logic quick_ramp_active,
  output logic motor_on,
  output logic ready_to_switch_on,
  output logic irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction

  function automatic logic fall(input logic prev, input logic cur);
    fall = prev & ~cur;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0] ctrl_q;
  logic [`STBS_CNT_W-1:0] tol_q;
  logic [`STBS_CNT_W-1:0] ssdly_q;
  stbs_pkg::stbs_evt_s irq_stat_q;
  stbs_pkg::stbs_evt_s irq_en_q;
  logic fault_q;
  logic cause_stage_q;
  logic fsin_q;
  logic run_q;
  logic sack_q;
  stbs_pkg::stbs_cw1_s cw1_q;
  stbs_pkg::stbs_ss_e ss_q;
  stbs_pkg::stbs_ss_e ss_d;
  logic [`STBS_CNT_W-1:0] ss_cnt_q;
  logic tq_off_prev_q;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire wr_ctrl = reg_wr && (reg_addr == `STBS_OFF_CTRL);
  wire wr_tol = reg_wr && (reg_addr == `STBS_OFF_TOL);
  wire wr_ssdly = reg_wr && (reg_addr == `STBS_OFF_SSDLY);
  wire wr_clr = reg_wr && (reg_addr == `STBS_OFF_IRQ_CLR);
  wire wr_en = reg_wr && (reg_addr == `STBS_OFF_IRQ_EN);

  wire [1:0] mode = ctrl_q[`STBS_CTRL_MODE_LSB +: 2];
  wire brake_cfg = ctrl_q[`STBS_CTRL_BRAKE_CFG];
  wire brk_en = ctrl_q[`STBS_CTRL_BRK_EN];
  wire tel_mode = (mode == `STBS_MODE_TEL_BASIC) || (mode == `STBS_MODE_TEL_EXT);

  // ----------------------------------------
  // Discrepancy on the power-stage terminals
  // ----------------------------------------
  logic stage_expired;

  stbs_discrepancy u_stage_disc (
    .mclk(mclk),
    .resetn(resetn),
    .chan_a(stage_term_a),
    .chan_b(stage_term_b),
    .tolerance(tol_q),
    .expired(stage_expired)
  );

  // ----------------------------------------
  // Acknowledgment paths
  // ----------------------------------------
  // Stage terminals are deliberately absent here
  wire ack_fsin = rise(fsin_q, failsafe_input);
  wire ack_tel = tel_mode &&
    (rise(cw1_q.torque_off_deselect_ext, tel_cw1.torque_off_deselect_ext) ||
     rise(cw1_q.safe_stop_deselect_ext, tel_cw1.safe_stop_deselect_ext) ||
     fall(cw1_q.ack, tel_cw1.ack));
  wire event_ack = ack_fsin || ack_tel;
  wire std_ack = rise(sack_q, standard_ack_source);
  wire run_rise = rise(run_q, run_command);

  // ----------------------------------------
  // Selections
  // ----------------------------------------
  wire stage_sel = ~stage_term_a | ~stage_term_b;
  wire tq_off_sel = ~failsafe_input | stage_sel |
                    (tel_mode & ~tel_cw1.torque_off_deselect_ext);
  wire ss_sel = ~safe_stop_deselect_basic |
                (tel_mode & ~tel_cw1.safe_stop_deselect_ext);
  wire ss_timeout = (ss_cnt_q >= ssdly_q);

  // A set pulse in the same cycle as an ack keeps the event raised
  wire event_d = stage_expired ? 1'b1 :
                 (event_ack ? 1'b0 : internal_event_flag);

  // Torque off forced by selection, internal event or finished safe stop
  wire tq_off_d = tq_off_sel | event_d | (ss_q == stbs_pkg::STBS_SS_DONE);
  wire brk_safe_d = brake_cfg & brk_en & tq_off_d;

  // Switch-on only on a fresh run edge with every blocker gone
  wire on_block = tq_off_sel | ss_sel | fault_q | internal_event_flag;
  wire motor_on_d = motor_on ? (run_command & quick_stop_cmd_n & ~tq_off_d &
                                (ss_q == stbs_pkg::STBS_SS_IDLE)) :
                               (run_rise & quick_stop_cmd_n & ~on_block & ~tq_off_d);

  // ----------------------------------------
  // Safe stop sequence
  // ----------------------------------------
  always_comb begin
    ss_d = ss_q;
    case (ss_q)
      stbs_pkg::STBS_SS_IDLE: begin
        if (ss_sel) begin
          // A motor already off goes straight to torque off
          ss_d = motor_on ? stbs_pkg::STBS_SS_RAMP : stbs_pkg::STBS_SS_DONE;
        end
      end
      stbs_pkg::STBS_SS_RAMP: begin
        if (!ss_sel) begin
          ss_d = stbs_pkg::STBS_SS_IDLE;
        end else if (at_standstill || ss_timeout) begin
          ss_d = stbs_pkg::STBS_SS_DONE;
        end
      end
      stbs_pkg::STBS_SS_DONE: begin
        if (!ss_sel) begin
          ss_d = stbs_pkg::STBS_SS_IDLE;
        end
      end
      default: begin
        ss_d = stbs_pkg::STBS_SS_DONE;
      end
    endcase
  end

  wire ss_ramp_d = (ss_d == stbs_pkg::STBS_SS_RAMP);
  wire ss_done_evt = (ss_d == stbs_pkg::STBS_SS_DONE) && (ss_q != stbs_pkg::STBS_SS_DONE);

  // Brake stays open while the ramp still turns the motor, closes at standstill
  wire close_d = (~motor_on_d & ~ss_ramp_d) | (ss_ramp_d & at_standstill) | brk_safe_d |
                 (ss_d == stbs_pkg::STBS_SS_DONE);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ss_q <= stbs_pkg::STBS_SS_IDLE;
      ss_cnt_q <= '0;
    end else begin
      ss_q <= ss_d;
      ss_cnt_q <= (ss_q == stbs_pkg::STBS_SS_RAMP) ? ss_cnt_q + 1'b1 : '0;
    end
  end

  // ----------------------------------------
  // Fault, event and drive outputs
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      internal_event_flag <= 1'b0;
      fault_q <= 1'b0;
      cause_stage_q <= 1'b0;
      fault_value_field <= 16'h0000;
      // Detectors start at each pin's idle level; a run held high needs a new edge
      fsin_q <= 1'b1;
      run_q <= 1'b1;
      sack_q <= 1'b0;
      cw1_q <= 8'h7F;
      tq_off_prev_q <= 1'b1;
    end else begin
      fsin_q <= failsafe_input;
      run_q <= run_command;
      sack_q <= standard_ack_source;
      cw1_q <= tel_cw1;
      tq_off_prev_q <= tq_off_d;
      internal_event_flag <= event_d;
      cause_stage_q <= stage_sel;
      if (stage_expired) begin
        fault_q <= 1'b1;
        fault_value_field <= `STBS_FAULT_DISCREPANCY;
      end else if (std_ack && !internal_event_flag) begin
        fault_q <= 1'b0;
        fault_value_field <= 16'h0000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      torque_off_active_basic <= 1'b1;
      brake_control_safe <= 1'b0;
      close_brake_cmd <= 1'b1;
      release_brake_cmd <= 1'b0;
      quick_ramp_active <= 1'b0;
      motor_on <= 1'b0;
      ready_to_switch_on <= 1'b0;
    end else begin
      torque_off_active_basic <= tq_off_d;
      brake_control_safe <= brk_safe_d;
      close_brake_cmd <= close_d;
      release_brake_cmd <= ~close_d;
      quick_ramp_active <= ss_ramp_d;
      motor_on <= motor_on_d;
      // Ready tells the controller when switch-on will be taken
      ready_to_switch_on <= ~motor_on_d & ~on_block & ~tq_off_d;
    end
  end

  // ----------------------------------------
  // Register file and interrupt
  // ----------------------------------------
  stbs_pkg::stbs_evt_s evt;
  assign evt.discrepancy = stage_expired;
  assign evt.torque_off_on = tq_off_d & ~tq_off_prev_q;
  assign evt.safe_stop_done = ss_done_evt;

  wire [2:0] clr_bits = wr_clr ? reg_wdata[2:0] : 3'h0;
  wire [2:0] stat_d = evt | (irq_stat_q & ~clr_bits);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_q <= `STBS_CTRL_RESET;
      tol_q <= `STBS_CNT_W'(`STBS_TOL_CYC);
      ssdly_q <= `STBS_CNT_W'(`STBS_SSDLY_CYC);
      irq_stat_q <= 3'h0;
      irq_en_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata[3:0];
      if (wr_tol) tol_q <= reg_wdata[`STBS_CNT_W-1:0];
      if (wr_ssdly) ssdly_q <= reg_wdata[`STBS_CNT_W-1:0];
      if (wr_en) irq_en_q <= reg_wdata[2:0];
      // Set wins over a clear in the same cycle
      irq_stat_q <= stat_d;
      irq <= |(stat_d & (wr_en ? reg_wdata[2:0] : irq_en_q));
    end
  end

  logic [31:0] state_word;
  always_comb begin
    state_word = 32'h0000_0000;
    state_word[`STBS_ST_EVENT] = internal_event_flag;
    state_word[`STBS_ST_FAULT] = fault_q;
    state_word[`STBS_ST_TQ_OFF] = torque_off_active_basic;
    state_word[`STBS_ST_BRK_SAFE] = brake_control_safe;
    state_word[`STBS_ST_MOTOR_ON] = motor_on;
    state_word[`STBS_ST_READY] = ready_to_switch_on;
    state_word[`STBS_ST_CAUSE_STAGE] = cause_stage_q;
    state_word[`STBS_ST_FVAL_LSB +: 16] = fault_value_field;
  end

  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `STBS_OFF_CTRL: rd_mux = {28'h0, ctrl_q};
      `STBS_OFF_TOL: rd_mux = {8'h00, tol_q};
      `STBS_OFF_SSDLY: rd_mux = {8'h00, ssdly_q};
      `STBS_OFF_STATE: rd_mux = state_word;
      `STBS_OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
      `STBS_OFF_IRQ_EN: rd_mux = {29'h0, irq_en_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // stbs_top

`default_nettype wire

// ---- verif/stbs_ctrl_model.sv ----
// Behavioural safety controller and motor speed
`timescale 1ns/1ns
`default_nettype none

module stbs_ctrl_model (
  input wire logic mclk,
  input wire logic motor_on,
  input wire logic ramp,
  output logic failsafe_input,
  output logic safe_stop_deselect_basic,
  output logic [7:0] tel_cw1,
  output logic standard_ack_source,
  output logic run_command,
  output logic quick_stop_cmd_n,
  output logic at_standstill
);
  int spin = 3;
  int cnt = 0;

  initial begin
    failsafe_input = 1'b1;
    safe_stop_deselect_basic = 1'b1;
    tel_cw1 = 8'h03;
    standard_ack_source = 1'b0;
    run_command = 1'b0;
    quick_stop_cmd_n = 1'b1;
    at_standstill = 1'b1;
  end

  // Speed decays once the motor is off or ramping; spin sets how slowly
  always @(posedge mclk) begin
    if (motor_on && !ramp) begin
      cnt <= 0;
      at_standstill <= 1'b0;
    end else if (cnt >= spin) begin
      at_standstill <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end

  task automatic sel(input logic fsin, input logic ss);
    @(posedge mclk);
    failsafe_input <= fsin;
    safe_stop_deselect_basic <= ss;
  endtask

  task automatic on;
    @(posedge mclk);
    run_command <= 1'b0;
    @(posedge mclk);
    run_command <= 1'b1;
  endtask

  task automatic ack(input int w);
    logic [7:0] m;
    m = (w == 1) ? 8'h01 : (w == 2) ? 8'h02 : 8'h80;
    repeat (2) begin
      @(posedge mclk);
      if (w == 0) begin
        failsafe_input <= !failsafe_input;
      end else begin
        tel_cw1 <= tel_cw1 ^ m;
      end
    end
  endtask

  task automatic restart(input int w);
    ack(w);
    @(posedge mclk);
    standard_ack_source <= 1'b1;
    @(posedge mclk);
    standard_ack_source <= 1'b0;
    on();
  endtask

  // Motor is brought down before torque off is selected
  task automatic stop;
    int k;
    @(posedge mclk);
    quick_stop_cmd_n <= 1'b0;
    run_command <= 1'b0;
    for (k = 0; k < 500 && !at_standstill; k++) @(posedge mclk);
    failsafe_input <= 1'b0;
    quick_stop_cmd_n <= 1'b1;
  endtask
endmodule // stbs_ctrl_model
`default_nettype wire

// ---- verif/stbs_monitor.sv ----
// Port checker for the safety sequencer
`timescale 1ns/1ns
`default_nettype none

module stbs_monitor (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic stage_term_a,
  input wire logic stage_term_b,
  input wire logic failsafe_input,
  input wire logic safe_stop_deselect_basic,
  input wire stbs_pkg::stbs_cw1_s tel_cw1,
  input wire logic at_standstill,
  input wire logic internal_event_flag,
  input wire logic [15:0] fault_value_field,
  input wire logic torque_off_active_basic,
  input wire logic brake_control_safe,
  input wire logic close_brake_cmd,
  input wire logic release_brake_cmd,
  input wire logic quick_ramp_active,
  input wire logic motor_on
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Tolerance of at least one cycle is assumed by the test setup
  property p_cause;
    $rose(internal_event_flag) |-> $past(stage_term_a ^ stage_term_b, 3);
  endproperty
  a_cause: assert property (p_cause) else $error("event without lasting discrepancy");
  property p_val;
    $rose(internal_event_flag) |-> fault_value_field == 16'h0406;
  endproperty
  a_val: assert property (p_val) else $error("wrong fault value");
  // Stage terminals are not an acknowledge path
  property p_clr;
    $fell(internal_event_flag) |->
      ($past(failsafe_input) != $past(failsafe_input, 2)) || ($past(tel_cw1) != $past(tel_cw1, 2));
  endproperty
  a_clr: assert property (p_clr) else $error("event cleared without ack edge");
  property p_brk_safe;
    brake_control_safe |-> torque_off_active_basic || $past(torque_off_active_basic);
  endproperty
  a_brk_safe: assert property (p_brk_safe) else $error("brake control without torque off");
  property p_tq;
    motor_on |-> !torque_off_active_basic;
  endproperty
  a_tq: assert property (p_tq) else $error("motor on with torque off");
  property p_ramp;
    $rose(quick_ramp_active) |-> $past(motor_on);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp without running motor");
  property p_still;
    quick_ramp_active && at_standstill |-> ##[1:2] (torque_off_active_basic && close_brake_cmd);
  endproperty
  a_still: assert property (p_still) else $error("no torque off at standstill");
  property p_brk;
    close_brake_cmd != release_brake_cmd;
  endproperty
  a_brk: assert property (p_brk) else $error("brake commands not complementary");
  // Brake must stay open while the ramp is still turning the motor
  property p_open;
    quick_ramp_active && !$past(at_standstill) && !torque_off_active_basic |-> release_brake_cmd;
  endproperty
  a_open: assert property (p_open) else $error("brake closed before standstill");
  property p_on;
    $rose(motor_on) |-> $past(safe_stop_deselect_basic) && $past(failsafe_input);
  endproperty
  a_on: assert property (p_on) else $error("switch-on while stop selected");

  c_evt: cover property ($rose(internal_event_flag));
  c_ramp: cover property ($rose(quick_ramp_active));
  c_on: cover property ($rose(motor_on));
endmodule // stbs_monitor

bind stbs_top stbs_monitor mon (.mclk(mclk), .resetn(resetn), .stage_term_a(stage_term_a),
  .stage_term_b(stage_term_b), .failsafe_input(failsafe_input),
  .safe_stop_deselect_basic(safe_stop_deselect_basic), .tel_cw1(tel_cw1),
  .at_standstill(at_standstill), .internal_event_flag(internal_event_flag),
  .fault_value_field(fault_value_field), .torque_off_active_basic(torque_off_active_basic),
  .brake_control_safe(brake_control_safe), .close_brake_cmd(close_brake_cmd),
  .release_brake_cmd(release_brake_cmd), .quick_ramp_active(quick_ramp_active),
  .motor_on(motor_on));
`default_nettype wire

// ---- verif/stbs_tb.sv ----
// Self-checking testbench of the safety sequencer
`timescale 1ns/1ns
`default_nettype none
`include "stbs_consts.svh"

module tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic stage_term_a = 1'b1;
  logic stage_term_b = 1'b1;
  logic [`STBS_ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fsi, ssd, sack, run, qsn, still, flag, tq, bcs, cls, rel, ramp, mon, rdy, irq;
  logic [7:0] cw1;
  logic [15:0] fval;
  logic [31:0] reg_rdata;
  int num_errors = 0;
  int n_tests = 0;

  stbs_ctrl_model ctl (.mclk(mclk), .motor_on(mon), .ramp(ramp), .failsafe_input(fsi),
    .safe_stop_deselect_basic(ssd), .tel_cw1(cw1), .standard_ack_source(sack),
    .run_command(run), .quick_stop_cmd_n(qsn), .at_standstill(still));

  stbs_top uut (.mclk(mclk), .resetn(resetn), .stage_term_a(stage_term_a),
    .stage_term_b(stage_term_b), .failsafe_input(fsi), .safe_stop_deselect_basic(ssd),
    .tel_cw1(cw1), .standard_ack_source(sack), .run_command(run), .quick_stop_cmd_n(qsn),
    .at_standstill(still), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .internal_event_flag(flag),
    .fault_value_field(fval), .torque_off_active_basic(tq), .brake_control_safe(bcs),
    .close_brake_cmd(cls), .release_brake_cmd(rel), .quick_ramp_active(ramp),
    .motor_on(mon), .ready_to_switch_on(rdy), .irq(irq));

  initial begin
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask

  // Bounded wait so a stuck sequencer cannot hang the run
  task automatic wait_rdy;
    int k;
    for (k = 0; k < 300 && rdy !== 1'b1; k++) @(posedge mclk);
    chk("ready", rdy, 1);
    ctl.on();
    tick(3);
    chk("motor_on", mon, 1);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    complete_run();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    tick(8);
    resetn <= 1'b1;
    rd(`STBS_OFF_CTRL, 32'h0);
    rd(`STBS_OFF_TOL, 32'h9C4);
    rd(`STBS_OFF_SSDLY, 32'hEA6);
    rd(8'h1C, 32'h0);
    rd(`STBS_OFF_IRQ_CLR, 32'h0);
    wr(`STBS_OFF_TOL, 32'hA);
    wr(`STBS_OFF_SSDLY, 32'h28);
    wr(`STBS_OFF_CTRL, 32'hC);
    wr(`STBS_OFF_IRQ_EN, 32'h7);
    ctl.on();
    tick(3);
    chk("release", rel, 1);
    ctl.stop();
    tick(4);
    chk("brake_safe", bcs, 1);
    for (int i = 0; i < 3; i++) begin
      wr(`STBS_OFF_CTRL, 32'(i * 4));
      tick(2);
      chk("brake_safe", bcs, 0);
    end
    wr(`STBS_OFF_CTRL, 32'hC);
    ctl.on();
    tick(3);
    chk("motor_on", mon, 0);
    ctl.sel(1'b1, 1'b1);
    wait_rdy();
    ctl.spin = 200;
    ctl.sel(1'b1, 1'b0);
    tick(3);
    chk("ramp", ramp, 1);
    chk("close", cls, 0);
    tick(25);
    chk("tq_off", tq, 0);
    tick(20);
    chk("tq_off", tq, 1);
    chk("close", cls, 1);
    rd(`STBS_OFF_IRQ_STAT, 32'h6);
    ctl.on();
    tick(3);
    chk("motor_on", mon, 0);
    ctl.sel(1'b1, 1'b1);
    wait_rdy();
    ctl.spin = 3;
    ctl.sel(1'b1, 1'b0);
    tick(10);
    chk("close", cls, 1);
    chk("tq_off", tq, 1);
    ctl.sel(1'b1, 1'b1);
    wait_rdy();
    for (int w = 0; w < 4; w++) begin
      wr(`STBS_OFF_CTRL, 32'hC | ((w == 3) ? 32'h2 : (w == 0) ? 32'h0 : 32'h1));
      stage_term_b <= 1'b0;
      tick(16);
      chk("event", flag, 1);
      chk("fault_value", fval, `STBS_FAULT_DISCREPANCY);
      stage_term_b <= 1'b1;
      tick(1);
      stage_term_a <= 1'b0;
      stage_term_b <= 1'b0;
      tick(1);
      stage_term_a <= 1'b1;
      stage_term_b <= 1'b1;
      tick(3);
      chk("event", flag, 1);
      ctl.restart(w);
      tick(3);
      chk("event", flag, 0);
      chk("fault_value", fval, 0);
      chk("motor_on", mon, 1);
    end
    rd(`STBS_OFF_IRQ_STAT, 32'h7);
    wr(`STBS_OFF_IRQ_EN, 32'h0);
    tick(2);
    chk("irq", irq, 0);
    wr(`STBS_OFF_IRQ_EN, 32'h7);
    tick(2);
    chk("irq", irq, 1);
    wr(`STBS_OFF_IRQ_CLR, 32'h7);
    tick(2);
    chk("irq", irq, 0);
    rd(`STBS_OFF_IRQ_STAT, 32'h0);
    stage_term_b <= 1'b0;
    tick(16);
    chk("event", flag, 1);
    resetn <= 1'b0;
    stage_term_b <= 1'b1;
    tick(8);
    resetn <= 1'b1;
    tick(2);
    chk("event", flag, 0);
    chk("motor_on", mon, 0);
    complete_run();
  end
endmodule // tb
`default_nettype wire
